// ### pim_assertions.sv
// Checker for the process image mapper, bound to pim_mapper.
// Assumes one AHB-Lite master and word writes.
`timescale 1ns/100ps
module pim_chk #(
    parameter N_AI  = 4,
    parameter N_DI8 = 1,
    parameter N_DI4 = 1,
    parameter N_AO  = 2,
    parameter N_DO8 = 1,
    parameter N_DO4 = 1
) (
    input wire               i_clock,
    input wire               i_rst,
    input wire               i_hsel,
    input wire [31:0]        i_haddr,
    input wire [1:0]         i_htrans,
    input wire               i_hwrite,
    input wire [2:0]         i_hsize,
    input wire [31:0]        i_hwdata,
    input wire               i_hready,
    input wire [31:0]        o_hrdata,
    input wire [16*N_AI-1:0] i_ai_byte,
    input wire [8*N_DI8-1:0] i_input_channel_bit8,
    input wire [4*N_DI4-1:0] i_input_channel_bit4,
    input wire [16*N_AO-1:0] o_ao_value,
    input wire [8*N_DO8-1:0] o_do8,
    input wire [4*N_DO4-1:0] o_do4,
    input wire               o_do1_ch,
    input wire [1:0]         o_dodiag_ch,
    input wire [1:0]         o_dodiag2_ch
);
    wire       take = i_hsel & i_htrans[1] & i_hready;
    wire       rd   = take & ~i_hwrite;
    reg        wr_pend;
    reg [11:0] wr_addr;

    // Pending word write, valid in its data phase
    always @(posedge i_clock) begin
        if (i_rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else if (i_hready) begin
            wr_pend <= take & i_hwrite & (i_hsize == 3'h2);
            wr_addr <= i_haddr[11:0];
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    ao_write_a: assert property (
        wr_pend && wr_addr == 12'h400 |=> o_ao_value[15:0] == $past(i_hwdata[15:0]))
        else $error("analog output word not applied");
    do8_write_a: assert property (
        wr_pend && wr_addr == 12'h408 |=> o_do8[7:0] == $past(i_hwdata[7:0]))
        else $error("eight channel outputs not applied");
    do4_write_a: assert property (
        wr_pend && wr_addr == 12'h408 |=> o_do4[3:0] == $past(i_hwdata[11:8]))
        else $error("four channel outputs not applied");
    do1_write_a: assert property (
        wr_pend && wr_addr == 12'h40C |=> o_do1_ch == $past(i_hwdata[8]))
        else $error("single channel output not applied");
    diag_write_a: assert property (
        wr_pend && wr_addr == 12'h410 |=> o_dodiag_ch == $past(i_hwdata[1:0]))
        else $error("diagnostic outputs not applied");
    diag2_write_a: assert property (
        wr_pend && wr_addr == 12'h410 |=> o_dodiag2_ch == $past(i_hwdata[9:8]))
        else $error("coded diagnostic outputs not applied");
    bit_read_a: assert property (
        rd && i_haddr[11:0] == 12'h018 && !$past(i_rst)
        && $stable(i_input_channel_bit8[7:0]) && $stable(i_input_channel_bit4[3:0])
        |=> o_hrdata == {20'h0_0000, $past(i_input_channel_bit4[3:0]),
                         $past(i_input_channel_bit8[7:0])})
        else $error("digital input byte misplaced");
    ai_read_a: assert property (
        rd && i_haddr[11:0] == 12'h014 && !$past(i_rst) && $stable(i_ai_byte[63:48])
        |=> o_hrdata == {16'h0000, $past(i_ai_byte[63:48])})
        else $error("fourth analog channel misplaced");
    upper_zero_a: assert property (
        rd |=> o_hrdata[31:16] == 16'h0000)
        else $error("unused upper half not zero");
endmodule

bind pim_mapper pim_chk #(.N_AI(N_AI), .N_DI8(N_DI8), .N_DI4(N_DI4), .N_AO(N_AO),
    .N_DO8(N_DO8), .N_DO4(N_DO4)) u_chk (.i_clock(i_clock), .i_rst(i_rst),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .i_ai_byte(i_ai_byte), .i_input_channel_bit8(i_input_channel_bit8),
    .i_input_channel_bit4(i_input_channel_bit4), .o_ao_value(o_ao_value),
    .o_do8(o_do8), .o_do4(o_do4), .o_do1_ch(o_do1_ch), .o_dodiag_ch(o_dodiag_ch),
    .o_dodiag2_ch(o_dodiag2_ch));

// ### pim_in_image.v
// Builds the input process image from the attached module data, one clock late.
// Assumes all module inputs are synchronous to i_clock.
`timescale 1ns/100ps
`include "pim_map.vh"

module pim_in_image #(
    parameter N_AI     = 4,
    parameter N_DI8    = 1,
    parameter N_DI4    = 1,
    parameter IN_WORDS = 10
) (
    input  wire                  i_clock,
    input  wire                  i_rst,
    input  wire [15:0]           i_ai1_value,
    input  wire [15:0]           i_ai1_ref,
    input  wire [16*N_AI-1:0]    i_ai_byte,
    input  wire [8*N_DI8-1:0]    i_input_channel_bit8,
    input  wire [4*N_DI4-1:0]    i_input_channel_bit4,
    input  wire                  i_do1_manual,
    input  wire [1:0]            i_dodiag_fault,
    input  wire [3:0]            i_dodiag2_fault,
    output reg  [16*IN_WORDS-1:0] o_image
);

    localparam DB    = N_DI8 + N_DI4 + 3;
    localparam AIW   = 2 + N_AI;
    localparam FIXED = N_DI8 + N_DI4;

    wire [8*DB-1:0]        dig;
    wire [16*IN_WORDS-1:0] next_image;

    // ********************************
    // Digital bytes: 8-ch, 4-ch, then output-module feedback bytes
    // ********************************
    genvar j;
    generate
        for (j = 0; j < N_DI8; j = j + 1) begin : g_di8
            assign dig[8*j +: 8] = i_input_channel_bit8[8*j +: 8];
        end
        for (j = 0; j < N_DI4; j = j + 1) begin : g_di4
            assign dig[8*(N_DI8+j) +: 8] = {4'h0, i_input_channel_bit4[4*j +: 4]};
        end
    endgenerate

    assign dig[8*FIXED +: 8]     = {7'h00, i_do1_manual};
    assign dig[8*(FIXED+1) +: 8] = {6'h00, i_dodiag_fault};
    assign dig[8*(FIXED+2) +: 8] = {4'h0, i_dodiag2_fault};

    // ********************************
    // Word layout: analog words first, then digital bytes
    // ********************************
    // Each channel word holds its even byte low and odd byte high
    assign next_image[16*AIW-1:0] = {i_ai_byte, i_ai1_ref, i_ai1_value};
    assign next_image[16*AIW +: 8*DB] = dig;

    generate
        if (DB % 2 == 1) begin : g_pad
            assign next_image[16*IN_WORDS-1 -: 8] = `PIM_BM_NONE;
        end
    endgenerate

    always @(posedge i_clock) begin
        if (i_rst) begin
            o_image <= {IN_WORDS{`PIM_WORD_RST}};
        end else begin
            o_image <= next_image;
        end
    end

endmodule

// ### pim_io_model.sv
// Attached I/O modules: analog and digital sources and output feedback.
// Assumes plant values from the bench; every output changes after a rising edge.
`timescale 1ns/100ps
module pim_io_model (
    input  wire        i_clock,
    input  wire [95:0] i_ai,
    input  wire [11:0] i_bits,
    input  wire        i_manual,
    input  wire [1:0]  i_overload,
    input  wire [3:0]  i_code,
    input  wire [1:0]  i_dodiag_ch,
    input  wire [1:0]  i_dodiag2_ch,
    output reg  [15:0] o_ai1_value = 16'h0000,
    output reg  [15:0] o_ai1_ref   = 16'h0000,
    output reg  [63:0] o_ai_byte   = 64'h0000_0000_0000_0000,
    output reg  [7:0]  o_bit8      = 8'h00,
    output reg  [3:0]  o_bit4      = 4'h0,
    output reg         o_manual    = 1'b0,
    output reg  [1:0]  o_fault     = 2'h0,
    output reg  [3:0]  o_fault2    = 4'h0
);
    always @(posedge i_clock) begin
        // Only measured values leave the analog modules
        o_ai1_value <= i_ai[95:80];
        o_ai1_ref   <= i_ai[79:64];
        o_ai_byte   <= i_ai[63:0];
        o_bit8      <= i_bits[7:0];
        o_bit4      <= i_bits[11:8];
        o_manual    <= i_manual;
        // Faults show only on a driven channel
        o_fault     <= i_dodiag_ch & i_overload;
        o_fault2    <= {i_code[3:2] & {2{i_dodiag2_ch[1]}},
                        i_code[1:0] & {2{i_dodiag2_ch[0]}}};
    end
endmodule

// ### pim_irq.v
// Sticky event status with write-one-to-clear, a mask and one level interrupt.
// Assumes one-cycle event pulses and a one-cycle clear strobe from the bus side.
`timescale 1ns/100ps
`include "pim_map.vh"

module pim_irq #(
    parameter W = 3
) (
    input  wire         i_clock,
    input  wire         i_rst,
    input  wire [W-1:0] i_event,
    input  wire [W-1:0] i_clear,
    input  wire         i_mask_we,
    input  wire [W-1:0] i_mask_data,
    output reg  [W-1:0] o_status,
    output reg  [W-1:0] o_mask,
    output wire         o_irq
);

    // ********************************
    // Status and mask
    // ********************************
    // A new event wins over a clear in the same cycle
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_status <= `PIM_STATUS_RST;
            o_mask   <= `PIM_MASK_RST;
        end else begin
            o_status <= (o_status & ~i_clear) | i_event;
            if (i_mask_we) begin
                o_mask <= i_mask_data;
            end
        end
    end

    assign o_irq = |(o_status & o_mask);

endmodule

// ### pim_map.vh
// Address map, field positions and reset values of the process image mapper.
// Included by every design file of the mapper; definitions only.
`ifndef PIM_MAP_VH
`define PIM_MAP_VH

// ********************************
// Bus regions, selected by haddr[11:10]
// ********************************
`define PIM_REGION_IN    2'h0
`define PIM_REGION_OUT   2'h1
`define PIM_REGION_CTL   2'h2

// Control region word indices
`define PIM_STATUS_IDX   8'h00
`define PIM_MASK_IDX     8'h01

// ********************************
// Event bit positions in status and mask
// ********************************
`define PIM_EV_MANUAL    0
`define PIM_EV_DIAG      1
`define PIM_EV_DIAG2     2
`define PIM_EV_COUNT     3

// ********************************
// Writable bits per output byte
// ********************************
`define PIM_BM_FULL      8'hFF
`define PIM_BM_NIBBLE    8'h0F
`define PIM_BM_PAIR      8'h03
`define PIM_BM_SINGLE    8'h01
`define PIM_BM_NONE      8'h00

// ********************************
// Bus encodings and reset values
// ********************************
`define PIM_HSIZE_WORD   3'h2
`define PIM_RESP_OKAY    1'b0
`define PIM_STATUS_RST   3'h0
`define PIM_MASK_RST     3'h0
`define PIM_WORD_RST     16'h0000
`define PIM_RDATA_RST    32'h0000_0000

`endif

// ### pim_mapper.v
// Process image mapper: input and output images of a node reached over AHB-Lite.
// Assumes a single AHB-Lite master, word transfers, and synchronous module data.
//
// Notes on behaviour
// - One output image bit drives each digital channel.
// - Digital output bytes follow analog output words.
// - Input channel k sits at bit k-1.
// - Output channel k controlled by bit k-1.
// - Single output: manual flag, control both bit 0.
// - Two-channel fault flags at input bits 0, 1.
// - Two-bit fault codes at bits 0-3, outputs 0-1.
// - Only 16-bit analog values reach the image.
// - Analog words little-endian: even byte low.
// - Analog input words precede digital input data.
// - Single analog input: value word 0, reference 1.
// - Two analog channels at word offsets 0, 1.
// - Analog channel k at word offset k-1.
// - Each digital input gives one state bit.
// - Byte data first, then bits packed into words.
`timescale 1ns/100ps
`include "pim_map.vh"

module pim_mapper #(
    parameter N_AI  = 4,
    parameter N_DI8 = 1,
    parameter N_DI4 = 1,
    parameter N_AO  = 2,
    parameter N_DO8 = 1,
    parameter N_DO4 = 1,
    parameter N_DO2 = 1
) (
    input  wire                i_clock,
    input  wire                i_rst,
    // AHB-Lite slave
    input  wire                i_hsel,
    input  wire [31:0]         i_haddr,
    input  wire [1:0]          i_htrans,
    input  wire                i_hwrite,
    input  wire [2:0]          i_hsize,
    input  wire [31:0]         i_hwdata,
    input  wire                i_hready,
    output wire                o_hreadyout,
    output wire                o_hresp,
    output reg  [31:0]         o_hrdata,
    output wire                o_irq,
    // Analog input modules
    input  wire [15:0]         i_ai1_value,
    input  wire [15:0]         i_ai1_ref,
    input  wire [16*N_AI-1:0]  i_ai_byte,
    // Digital input modules
    input  wire [8*N_DI8-1:0]  i_input_channel_bit8,
    input  wire [4*N_DI4-1:0]  i_input_channel_bit4,
    // Feedback from output modules
    input  wire                i_do1_manual,
    input  wire [1:0]          i_dodiag_fault,
    input  wire [3:0]          i_dodiag2_fault,
    // Output modules
    output wire [16*N_AO-1:0]  o_ao_value,
    output wire [8*N_DO8-1:0]  o_do8,
    output wire [4*N_DO4-1:0]  o_do4,
    output wire [2*N_DO2-1:0]  o_do2,
    output wire                o_do1_ch,
    output wire [1:0]          o_dodiag_ch,
    output wire [1:0]          o_dodiag2_ch
);

    // ********************************
    // Image sizes
    // ********************************
    localparam DBI       = N_DI8 + N_DI4 + 3;
    localparam IN_WORDS  = 2 + N_AI + (DBI + 1) / 2;
    localparam DBO       = N_DO8 + N_DO4 + N_DO2 + 3;
    localparam OUT_WORDS = N_AO + (DBO + 1) / 2;
    localparam B_DO1     = N_DO8 + N_DO4 + N_DO2;
    localparam B_DIAG    = B_DO1 + 1;
    localparam B_DIAG2   = B_DO1 + 2;
    // Word counts as bounds for the index decode
    localparam [8:0] IN_LIMIT  = IN_WORDS[8:0];
    localparam [8:0] OUT_LIMIT = OUT_WORDS[8:0];

    // ********************************
    // Declarations
    // ********************************
    reg                        dp_valid;
    reg                        dp_write;
    reg  [11:0]                dp_addr;
    reg  [16*OUT_WORDS-1:0]    out_img;
    reg                        prev_manual;
    reg  [1:0]                 prev_diag;
    reg  [3:0]                 prev_diag2;
    reg  [31:0]                next_rdata;
    wire [16*IN_WORDS-1:0]     in_img;
    wire [16*OUT_WORDS-1:0]    out_mask;
    wire [8*DBO-1:0]           dig_out;
    wire                       take;
    wire [1:0]                 a_region;
    wire [7:0]                 a_idx;
    wire [1:0]                 dp_region;
    wire [7:0]                 dp_idx;
    wire                       wr_out;
    wire                       wr_status;
    wire                       wr_mask;
    wire [`PIM_EV_COUNT-1:0]   ev;
    wire [`PIM_EV_COUNT-1:0]   ev_clear;
    wire [`PIM_EV_COUNT-1:0]   status;
    wire [`PIM_EV_COUNT-1:0]   mask;

    // ********************************
    // Input image
    // ********************************
    pim_in_image #(
        .N_AI     (N_AI),
        .N_DI8    (N_DI8),
        .N_DI4    (N_DI4),
        .IN_WORDS (IN_WORDS)
    ) u_in_image (
        .i_clock              (i_clock),
        .i_rst                (i_rst),
        .i_ai1_value          (i_ai1_value),
        .i_ai1_ref            (i_ai1_ref),
        .i_ai_byte            (i_ai_byte),
        .i_input_channel_bit8 (i_input_channel_bit8),
        .i_input_channel_bit4 (i_input_channel_bit4),
        .i_do1_manual         (i_do1_manual),
        .i_dodiag_fault       (i_dodiag_fault),
        .i_dodiag2_fault      (i_dodiag2_fault),
        .o_image              (in_img)
    );

    // ********************************
    // AHB-Lite address phase
    // ********************************
    assign take      = i_hsel & i_htrans[1] & i_hready;
    assign a_region  = i_haddr[11:10];
    assign a_idx     = i_haddr[9:2];
    assign dp_region = dp_addr[11:10];
    assign dp_idx    = dp_addr[9:2];

    // Zero wait states, always OKAY
    assign o_hreadyout = 1'b1;
    assign o_hresp     = `PIM_RESP_OKAY;

    // Address phase kept for the data phase that follows
    always @(posedge i_clock) begin
        if (i_rst) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= 12'h000;
        end else if (i_hready) begin
            dp_valid <= take;
            dp_write <= take & i_hwrite & (i_hsize == `PIM_HSIZE_WORD);
            dp_addr  <= i_haddr[11:0];
        end
    end

    // ********************************
    // Read data, sampled at the address phase
    // ********************************
    // A read addressed in the data phase of a write
    // to the same word still returns the old value
    always @* begin
        next_rdata = `PIM_RDATA_RST;
        case (a_region)
            `PIM_REGION_IN: begin
                if ({1'b0, a_idx} < IN_LIMIT) begin
                    next_rdata[15:0] = in_img[16*a_idx +: 16];
                end
            end
            `PIM_REGION_OUT: begin
                if ({1'b0, a_idx} < OUT_LIMIT) begin
                    next_rdata[15:0] = out_img[16*a_idx +: 16];
                end
            end
            `PIM_REGION_CTL: begin
                if (a_idx == `PIM_STATUS_IDX) begin
                    next_rdata[`PIM_EV_COUNT-1:0] = status;
                end else if (a_idx == `PIM_MASK_IDX) begin
                    next_rdata[`PIM_EV_COUNT-1:0] = mask;
                end
            end
            // Unused region reads zero
            default: begin
                next_rdata = `PIM_RDATA_RST;
            end
        endcase
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            o_hrdata <= `PIM_RDATA_RST;
        end else if (take & ~i_hwrite) begin
            o_hrdata <= next_rdata;
        end
    end

    // ********************************
    // Data phase writes
    // ********************************
    // Non-word writes never get here: dp_write drops them
    assign wr_out    = dp_valid & dp_write & (dp_region == `PIM_REGION_OUT);
    assign wr_status = dp_valid & dp_write & (dp_region == `PIM_REGION_CTL)
                       & (dp_idx == `PIM_STATUS_IDX);
    assign wr_mask   = dp_valid & dp_write & (dp_region == `PIM_REGION_CTL)
                       & (dp_idx == `PIM_MASK_IDX);

    // ********************************
    // Output image: writable bits per byte
    // ********************************
    assign out_mask[16*N_AO-1:0] = {(2*N_AO){`PIM_BM_FULL}};

    genvar b;
    generate
        for (b = 0; b < 2 * (OUT_WORDS - N_AO); b = b + 1) begin : g_omask
            localparam [7:0] BM = (b < N_DO8)                 ? `PIM_BM_FULL   :
                                  (b < N_DO8 + N_DO4)         ? `PIM_BM_NIBBLE :
                                  (b < B_DO1)                 ? `PIM_BM_PAIR   :
                                  (b == B_DO1)                ? `PIM_BM_SINGLE :
                                  (b == B_DIAG || b == B_DIAG2) ? `PIM_BM_PAIR :
                                                                `PIM_BM_NONE;
            assign out_mask[16*N_AO + 8*b +: 8] = BM;
        end
    endgenerate

    // ********************************
    // Output image words
    // ********************************
    genvar w;
    generate
        for (w = 0; w < OUT_WORDS; w = w + 1) begin : g_oword
            localparam [31:0] IDX = w;
            // Masked bits stay zero whatever the write carries
            always @(posedge i_clock) begin
                if (i_rst) begin
                    out_img[16*w +: 16] <= `PIM_WORD_RST;
                end else if (wr_out && {24'h00_0000, dp_idx} == IDX) begin
                    out_img[16*w +: 16] <= i_hwdata[15:0] & out_mask[16*w +: 16];
                end
            end
        end
    endgenerate

    // ********************************
    // Channel drive from the output image
    // ********************************
    // Channel pins follow the image registers directly
    assign o_ao_value = out_img[16*N_AO-1:0];
    assign dig_out    = out_img[16*N_AO +: 8*DBO];

    genvar m;
    generate
        for (m = 0; m < N_DO8; m = m + 1) begin : g_do8
            assign o_do8[8*m +: 8] = dig_out[8*m +: 8];
        end
        for (m = 0; m < N_DO4; m = m + 1) begin : g_do4
            assign o_do4[4*m +: 4] = dig_out[8*(N_DO8+m) +: 4];
        end
        for (m = 0; m < N_DO2; m = m + 1) begin : g_do2
            assign o_do2[2*m +: 2] = dig_out[8*(N_DO8+N_DO4+m) +: 2];
        end
    endgenerate

    assign o_do1_ch     = dig_out[8*B_DO1];
    assign o_dodiag_ch  = dig_out[8*B_DIAG +: 2];
    assign o_dodiag2_ch = dig_out[8*B_DIAG2 +: 2];

    // ********************************
    // Events: manual mode entered, fault raised
    // ********************************
    always @(posedge i_clock) begin
        if (i_rst) begin
            prev_manual <= 1'b0;
            prev_diag   <= 2'h0;
            prev_diag2  <= 4'h0;
        end else begin
            prev_manual <= i_do1_manual;
            prev_diag   <= i_dodiag_fault;
            prev_diag2  <= i_dodiag2_fault;
        end
    end

    // A level already high at reset release counts as an event
    assign ev[`PIM_EV_MANUAL] = i_do1_manual & ~prev_manual;
    assign ev[`PIM_EV_DIAG]   = |(i_dodiag_fault & ~prev_diag);
    assign ev[`PIM_EV_DIAG2]  = (i_dodiag2_fault != prev_diag2) & (|i_dodiag2_fault);

    assign ev_clear = wr_status ? i_hwdata[`PIM_EV_COUNT-1:0] : {`PIM_EV_COUNT{1'b0}};

    pim_irq #(
        .W (`PIM_EV_COUNT)
    ) u_irq (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_event     (ev),
        .i_clear     (ev_clear),
        .i_mask_we   (wr_mask),
        .i_mask_data (i_hwdata[`PIM_EV_COUNT-1:0]),
        .o_status    (status),
        .o_mask      (mask),
        .o_irq       (o_irq)
    );

endmodule

// ### tb_top.sv
// Self-checking bench for the process image mapper over AHB-Lite.
// Assumes default parameters and the register map of the design header.
`timescale 1ns/100ps
module tb_top;
    reg         i_clock  = 1'b0;
    reg         i_rst    = 1'b1;
    reg         i_hsel   = 1'b0;
    reg  [31:0] i_haddr  = 32'h0000_0000;
    reg  [1:0]  i_htrans = 2'h0;
    reg         i_hwrite = 1'b0;
    reg  [2:0]  i_hsize  = 3'h2;
    reg  [31:0] i_hwdata = 32'h0000_0000;
    reg  [95:0] ai       = 96'h0;
    reg  [11:0] in_bits  = 12'h000;
    reg         manual   = 1'b0;
    reg  [1:0]  overload = 2'h0;
    reg  [3:0]  code     = 4'h0;
    wire        hready;
    wire        hresp;
    wire        irq;
    wire [31:0] hrdata;
    wire [15:0] ai1_v;
    wire [15:0] ai1_r;
    wire [63:0] ai_b;
    wire [7:0]  b8;
    wire [3:0]  b4;
    wire        man_w;
    wire [1:0]  flt;
    wire [3:0]  flt2;
    wire [31:0] ao;
    wire [7:0]  do8;
    wire [3:0]  do4;
    wire [1:0]  do2;
    wire        do1;
    wire [1:0]  dch;
    wire [1:0]  d2ch;
    reg  [31:0] rd;
    integer     bad_count    = 0;
    integer     total_checks = 0;
    integer     k;

    always #5 i_clock = ~i_clock;

    pim_io_model io (.i_clock(i_clock), .i_ai(ai), .i_bits(in_bits), .i_manual(manual),
        .i_overload(overload), .i_code(code), .i_dodiag_ch(dch), .i_dodiag2_ch(d2ch),
        .o_ai1_value(ai1_v), .o_ai1_ref(ai1_r), .o_ai_byte(ai_b), .o_bit8(b8),
        .o_bit4(b4), .o_manual(man_w), .o_fault(flt), .o_fault2(flt2));

    pim_mapper dut (.i_clock(i_clock), .i_rst(i_rst), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
        .i_hwdata(i_hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
        .o_hrdata(hrdata), .o_irq(irq), .i_ai1_value(ai1_v), .i_ai1_ref(ai1_r),
        .i_ai_byte(ai_b), .i_input_channel_bit8(b8), .i_input_channel_bit4(b4),
        .i_do1_manual(man_w), .i_dodiag_fault(flt), .i_dodiag2_fault(flt2),
        .o_ao_value(ao), .o_do8(do8), .o_do4(do4), .o_do2(do2), .o_do1_ch(do1),
        .o_dodiag_ch(dch), .o_dodiag2_ch(d2ch));

    // ********************************
    // Checking and bus tasks
    // ********************************
    task check(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task xfer(input w, input [11:0] a, input [31:0] wd, input [2:0] sz);
        begin
            i_hsel   <= 1'b1;
            i_haddr  <= {20'h0_0000, a};
            i_htrans <= 2'h2;
            i_hwrite <= w;
            i_hsize  <= sz;
            @(posedge i_clock);
            while (hready !== 1'b1) @(posedge i_clock);
            i_hsel   <= 1'b0;
            i_htrans <= 2'h0;
            i_hwdata <= wd;
            @(posedge i_clock);
            while (hready !== 1'b1) @(posedge i_clock);
            rd = hrdata;
        end
    endtask

    task wr(input [11:0] a, input [31:0] wd);
        xfer(1'b1, a, wd, 3'h2);
    endtask

    task rdc(input [11:0] a, input [31:0] exp);
        begin
            xfer(1'b0, a, 32'h0000_0000, 3'h2);
            check(rd, exp);
        end
    endtask

    task summarize;
        begin
            $display("checks %0d mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    initial begin
        #20000;
        bad_count = bad_count + 1;
        summarize;
    end

    // ********************************
    // Test sequence
    // ********************************
    initial begin
        repeat (12) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        rdc(12'h408, 32'h0000_0000);
        ai <= {16'h1234, 16'h5678, 64'h8877_6655_4433_2211};
        in_bits <= {4'h9, 8'hA5};
        repeat (3) @(posedge i_clock);
        rdc(12'h000, {16'h0000, ai[95:80]});
        rdc(12'h004, {16'h0000, ai[79:64]});
        for (k = 0; k < 4; k = k + 1) begin
            rdc(12'h008 + 4 * k, {16'h0000, ai[16*k+15 -: 16]});
        end
        rdc(12'h018, 32'h0000_09A5);
        wr(12'h400, 32'hFFFF_ABCD);
        @(posedge i_clock);
        check(ao, 32'h0000_ABCD);
        rdc(12'h400, 32'h0000_ABCD);
        for (k = 0; k < 8; k = k + 1) begin
            wr(12'h408, 32'h0000_0101 << k);
            @(posedge i_clock);
            check({20'h0_0000, do4, do8}, (32'h0000_0101 << k) & 32'h0000_0FFF);
        end
        wr(12'h408, 32'hFFFF_FFFF);
        rdc(12'h408, 32'h0000_0FFF);
        wr(12'h40C, 32'hFFFF_FFFF);
        @(posedge i_clock);
        check({do1, do2}, 3'h7);
        rdc(12'h40C, 32'h0000_0103);
        wr(12'h410, 32'hFFFF_FFFF);
        rdc(12'h410, 32'h0000_0303);
        check({d2ch, dch}, 4'hF);
        manual   <= 1'b1;
        overload <= 2'h1;
        code     <= 4'hB;
        repeat (3) @(posedge i_clock);
        rdc(12'h01C, 32'h0000_0101);
        rdc(12'h020, 32'h0000_000B);
        check(irq, 1'b0);
        rdc(12'h800, 32'h0000_0007);
        wr(12'h804, 32'h0000_0001);
        @(posedge i_clock);
        check(irq, 1'b1);
        wr(12'h800, 32'h0000_0001);
        @(posedge i_clock);
        check(irq, 1'b0);
        rdc(12'h800, 32'h0000_0006);
        wr(12'h804, 32'h0000_0007);
        @(posedge i_clock);
        check(irq, 1'b1);
        wr(12'h800, 32'h0000_0006);
        rdc(12'h800, 32'h0000_0000);
        check(irq, 1'b0);
        wr(12'h000, 32'hFFFF_FFFF);
        rdc(12'h000, 32'h0000_1234);
        xfer(1'b1, 12'h400, 32'h0000_1111, 3'h1);
        rdc(12'h400, 32'h0000_ABCD);
        rdc(12'hC00, 32'h0000_0000);
        check(hresp, 1'b0);
        i_rst <= 1'b1;
        @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        check({24'h00_0000, do8}, 32'h0000_0000);
        rdc(12'h804, 32'h0000_0000);
        summarize;
    end
endmodule
